// ---- hdl/rsasr_pkg.sv ----
// constants and register map of the range select and alarm status bank
package rsasr_pkg;
    // register byte addresses
    localparam logic [7:0]  RSASR_ADDR_RANGE     = 8'h14;
    localparam logic [7:0]  RSASR_ADDR_ALARM     = 8'h20;
    localparam logic [7:0]  RSASR_ADDR_UPPER     = 8'h24;
    localparam logic [7:0]  RSASR_ADDR_LOWER     = 8'h28;
    localparam logic [7:0]  RSASR_ADDR_IRQ_STAT  = 8'h30;
    localparam logic [7:0]  RSASR_ADDR_IRQ_MASK  = 8'h34;
    // widths
    localparam int          RSASR_RESULT_W       = 14;
    localparam int          RSASR_HYST_W         = 4;
    localparam int          RSASR_EV_W           = 4;
    // range select fields
    localparam int          RSASR_RANGE_LSB      = 0;
    localparam int          RSASR_RANGE_MSB      = 3;
    localparam int          RSASR_BIT_REF_OFF    = 6;
    localparam logic [3:0]  RSASR_RANGE_RST      = 4'h0;
    localparam logic        RSASR_REF_OFF_RST    = 1'b0;
    // alarm status fields
    localparam int          RSASR_BIT_SUP_UNDER  = 15;
    localparam int          RSASR_BIT_SUP_OVER   = 14;
    localparam int          RSASR_BIT_IN_UNDER   = 11;
    localparam int          RSASR_BIT_IN_OVER    = 10;
    localparam int          RSASR_TRIP_MSB       = 7;
    localparam int          RSASR_TRIP_LSB       = 4;
    localparam int          RSASR_BIT_ANY_TRIP   = 0;
    // limit fields
    localparam int          RSASR_LIMIT_MSB      = 15;
    localparam int          RSASR_CMP_LSB        = 2;
    localparam int          RSASR_HYST_BYTE_MSB  = 31;
    localparam int          RSASR_HYST_BYTE_LSB  = 24;
    localparam int          RSASR_HYST_MSB       = 7;
    localparam int          RSASR_HYST_LSB       = 4;
    localparam logic [15:0] RSASR_UPPER_RST      = 16'hFFFF;
    localparam logic [15:0] RSASR_LOWER_RST      = 16'h0000;
    localparam logic [7:0]  RSASR_HYST_RST       = 8'h00;
    // event order: supply under, supply over, input under, input over
    localparam logic [3:0]  RSASR_EV_RST         = 4'h0;
    // ahb
    localparam logic [1:0]  RSASR_HRESP_OKAY     = 2'h0;
    localparam logic [2:0]  RSASR_HSIZE_BYTE     = 3'h0;
    localparam logic [2:0]  RSASR_HSIZE_HALF     = 3'h1;
    typedef enum logic [3:0] {
        RSASR_BIP_3_0     = 4'h0,
        RSASR_BIP_2_5     = 4'h1,
        RSASR_BIP_1_5     = 4'h2,
        RSASR_BIP_1_25    = 4'h3,
        RSASR_BIP_0_625   = 4'h4,
        RSASR_UNI_3_0     = 4'h8,
        RSASR_UNI_2_5     = 4'h9,
        RSASR_UNI_1_5     = 4'hA,
        RSASR_UNI_1_25    = 4'hB
    } rsasr_range_t;
    typedef enum logic [1:0] {
        RSASR_ST_IDLE  = 2'h0,
        RSASR_ST_READ  = 2'h1,
        RSASR_ST_WRITE = 2'h2
    } rsasr_bus_t;
endpackage

// ---- hdl/rsasr_limit_cmp.sv ----
// input limit comparator with hysteresis
`timescale 1ns/1ns
module rsasr_limit_cmp #(
    parameter bit ABOVE = 1'b1
) (
    // clock and reset
    input  wire logic                                hclk,
    input  wire logic                                hresetn,
    // conversion sample
    input  wire logic                                sample,
    input  wire logic [rsasr_pkg::RSASR_RESULT_W-1:0] result,
    input  wire logic [rsasr_pkg::RSASR_RESULT_W-1:0] limit,
    input  wire logic [rsasr_pkg::RSASR_HYST_W-1:0]   hyst,
    // alarm
    output logic                                     active
);
    import rsasr_pkg::*;
    typedef struct packed {
        logic active;
    } rsasr_cmp_t;
    rsasr_cmp_t                st;
    rsasr_cmp_t                next_st;
    logic [RSASR_RESULT_W:0]   wide_r;
    logic [RSASR_RESULT_W:0]   wide_l;
    logic [RSASR_RESULT_W:0]   wide_h;
    logic                      trip;
    logic                      release_ok;

    always_comb begin
        next_st = st;
        wide_r = {1'b0, result};
        wide_l = {1'b0, limit};
        wide_h = (RSASR_RESULT_W + 1)'(hyst);
        if (ABOVE) begin
            trip = wide_r > wide_l;
            release_ok = (wide_r + wide_h) < wide_l;
        end else begin
            trip = wide_r < wide_l;
            release_ok = wide_r > (wide_l + wide_h);
        end
        if (sample) begin
            if (trip) begin
                next_st.active = 1'b1;
            end else if (release_ok) begin
                next_st.active = 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign active = st.active;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_cmp_trip_sets:   assert property (sample && trip |=> active)
        else $error("limit crossed but alarm not active");
    a_cmp_band_holds:  assert property (
        sample && !trip && !release_ok |=> active == $past(active))
        else $error("alarm changed inside hysteresis band");
    a_cmp_quiet:       assert property (!sample |=> $stable(active))
        else $error("alarm changed without a conversion");
endmodule

// ---- hdl/rsasr_evt_irq.sv ----
// sticky event status, mask and interrupt line
`timescale 1ns/1ns
module rsasr_evt_irq (
    // clock and reset
    input  wire logic                            hclk,
    input  wire logic                            hresetn,
    // events
    input  wire logic [rsasr_pkg::RSASR_EV_W-1:0] events,
    // software access
    input  wire logic                            clr_go,
    input  wire logic [rsasr_pkg::RSASR_EV_W-1:0] clr_bits,
    input  wire logic                            mask_go,
    input  wire logic [rsasr_pkg::RSASR_EV_W-1:0] mask_data,
    // state
    output logic      [rsasr_pkg::RSASR_EV_W-1:0] status,
    output logic      [rsasr_pkg::RSASR_EV_W-1:0] mask,
    output logic                                 irq
);
    import rsasr_pkg::*;
    typedef struct packed {
        logic [RSASR_EV_W-1:0] status;
        logic [RSASR_EV_W-1:0] mask;
        logic                  irq;
    } rsasr_irq_t;
    rsasr_irq_t st;
    rsasr_irq_t next_st;

    always_comb begin
        next_st = st;
        if (clr_go) begin
            next_st.status = st.status & ~clr_bits;
        end
        next_st.status = next_st.status | events;
        if (mask_go) begin
            next_st.mask = mask_data;
        end
        next_st.irq = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign status = st.status;
    assign mask   = st.mask;
    assign irq    = st.irq;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_evt_set_wins: assert property (
        (|events) |=> (status & $past(events)) == $past(events))
        else $error("event lost against clear");
    a_irq_level:    assert property (
        (|(status & mask)) |-> irq)
        else $error("interrupt low with unmasked status");
endmodule

// ---- hdl/rsasr_regs.sv ----
// range select and alarm status register bank on ahb-lite
`timescale 1ns/1ns
module rsasr_regs (
    // clock and reset
    input  wire logic                                hclk,
    input  wire logic                                hresetn,
    // ahb-lite slave
    input  wire logic                                hsel,
    input  wire logic [31:0]                         haddr,
    input  wire logic [1:0]                          htrans,
    input  wire logic                                hwrite,
    input  wire logic [2:0]                          hsize,
    input  wire logic [31:0]                         hwdata,
    input  wire logic                                hready,
    output logic                                     hreadyout,
    output logic      [31:0]                         hrdata,
    output logic      [1:0]                          hresp,
    // converter side
    input  wire logic                                conv_start,
    input  wire logic                                conv_done,
    input  wire logic [rsasr_pkg::RSASR_RESULT_W-1:0] conv_result,
    input  wire logic                                supply_under,
    input  wire logic                                supply_over,
    // controls to the converter
    output logic      [3:0]                          applied_range,
    output logic                                     onchip_reference_off,
    // interrupt
    output logic                                     irq
);
    import rsasr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        rsasr_bus_t            bus;
        logic                  hreadyout;
        logic [31:0]           hrdata;
        logic [1:0]            hresp;
        logic [7:0]            addr;
        logic [3:0]            be;
        logic [3:0]            range_code;
        logic                  ref_off;
        logic [7:0]            hyst_byte;
        logic [15:0]           upper;
        logic [15:0]           lower;
        logic                  sup_under;
        logic                  sup_over;
        logic                  upd;
        logic [RSASR_EV_W-1:0] tripped;
        logic [3:0]            applied_range;
    } rsasr_main_t;

    localparam rsasr_main_t RSASR_MAIN_RST = '{
        bus:           RSASR_ST_IDLE,
        hreadyout:     1'b1,
        hrdata:        32'h0000_0000,
        hresp:         RSASR_HRESP_OKAY,
        addr:          8'h00,
        be:            4'h0,
        range_code:    RSASR_RANGE_RST,
        ref_off:       RSASR_REF_OFF_RST,
        hyst_byte:     RSASR_HYST_RST,
        upper:         RSASR_UPPER_RST,
        lower:         RSASR_LOWER_RST,
        sup_under:     1'b0,
        sup_over:      1'b0,
        upd:           1'b0,
        tripped:       RSASR_EV_RST,
        applied_range: RSASR_RANGE_RST
    };

    rsasr_main_t           st;
    rsasr_main_t           next_st;
    logic [1:0]            in_act;
    logic [RSASR_EV_W-1:0] act_vec;
    logic [RSASR_EV_W-1:0] ev_new;
    logic [RSASR_EV_W-1:0] irq_status;
    logic [RSASR_EV_W-1:0] irq_mask;
    logic [31:0]           alarm_word;
    logic [31:0]           range_word;
    logic [31:0]           upper_word;
    logic [31:0]           lower_word;
    logic [31:0]           rd_sel;
    logic [31:0]           lanes;
    logic [31:0]           merged;
    logic                  wr_go;
    logic                  rd_alarm;
    logic                  clr_go;
    logic                  mask_go;

    function automatic logic [3:0] lane_mask(input logic [2:0] size,
                                             input logic [1:0] a);
        logic [3:0] m;
        m = 4'hF;
        if (size == RSASR_HSIZE_BYTE) begin
            m = 4'h1 << a;
        end else if (size == RSASR_HSIZE_HALF) begin
            m = a[1] ? 4'hC : 4'h3;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input limit comparators: 0 over, 1 under
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_cmp
            rsasr_limit_cmp #(
                .ABOVE (g == 0)
            ) u_cmp (
                .hclk    (hclk),
                .hresetn (hresetn),
                .sample  (conv_done),
                .result  (conv_result),
                .limit   ((g == 0) ? st.upper[RSASR_LIMIT_MSB:RSASR_CMP_LSB]
                                   : st.lower[RSASR_LIMIT_MSB:RSASR_CMP_LSB]),
                .hyst    (st.hyst_byte[RSASR_HYST_MSB:RSASR_HYST_LSB]),
                .active  (in_act[g])
            );
        end
    endgenerate

    rsasr_evt_irq u_irq (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .events    (ev_new),
        .clr_go    (clr_go),
        .clr_bits  (hwdata[RSASR_EV_W-1:0] & lanes[RSASR_EV_W-1:0]),
        .mask_go   (mask_go),
        .mask_data (merged[RSASR_EV_W-1:0]),
        .status    (irq_status),
        .mask      (irq_mask),
        .irq       (irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st = st;
        act_vec = {st.sup_under, st.sup_over, in_act[1], in_act[0]};
        alarm_word = '0;
        alarm_word[RSASR_BIT_SUP_UNDER] = st.sup_under;
        alarm_word[RSASR_BIT_SUP_OVER] = st.sup_over;
        alarm_word[RSASR_BIT_IN_UNDER] = in_act[1];
        alarm_word[RSASR_BIT_IN_OVER] = in_act[0];
        alarm_word[RSASR_TRIP_MSB:RSASR_TRIP_LSB] = st.tripped;
        alarm_word[RSASR_BIT_ANY_TRIP] = |st.tripped;
        range_word = '0;
        range_word[RSASR_BIT_REF_OFF] = st.ref_off;
        range_word[RSASR_RANGE_MSB:RSASR_RANGE_LSB] = st.range_code;
        upper_word = '0;
        upper_word[RSASR_HYST_BYTE_MSB:RSASR_HYST_BYTE_LSB] = st.hyst_byte;
        upper_word[RSASR_LIMIT_MSB:0] = st.upper;
        lower_word = '0;
        lower_word[RSASR_LIMIT_MSB:0] = st.lower;
        if (st.addr == RSASR_ADDR_RANGE) begin
            rd_sel = range_word;
        end else if (st.addr == RSASR_ADDR_ALARM) begin
            rd_sel = alarm_word;
        end else if (st.addr == RSASR_ADDR_UPPER) begin
            rd_sel = upper_word;
        end else if (st.addr == RSASR_ADDR_LOWER) begin
            rd_sel = lower_word;
        end else if (st.addr == RSASR_ADDR_IRQ_STAT) begin
            rd_sel = 32'(irq_status);
        end else if (st.addr == RSASR_ADDR_IRQ_MASK) begin
            rd_sel = 32'(irq_mask);
        end else begin
            rd_sel = '0;
        end
        lanes = {{8{st.be[3]}}, {8{st.be[2]}}, {8{st.be[1]}}, {8{st.be[0]}}};
        merged = (rd_sel & ~lanes) | (hwdata & lanes);
        wr_go = st.bus == RSASR_ST_WRITE;
        rd_alarm = (st.bus == RSASR_ST_READ) && (st.addr == RSASR_ADDR_ALARM);
        clr_go = wr_go && (st.addr == RSASR_ADDR_IRQ_STAT);
        mask_go = wr_go && (st.addr == RSASR_ADDR_IRQ_MASK);
        ev_new = st.upd ? (act_vec & ~st.tripped) : '0;

        // register writes; the alarm word is read only
        if (wr_go && st.addr == RSASR_ADDR_RANGE) begin
            next_st.ref_off = merged[RSASR_BIT_REF_OFF];
            next_st.range_code =
                merged[RSASR_RANGE_MSB:RSASR_RANGE_LSB];
        end else if (wr_go && st.addr == RSASR_ADDR_UPPER) begin
            next_st.hyst_byte =
                merged[RSASR_HYST_BYTE_MSB:RSASR_HYST_BYTE_LSB];
            next_st.upper = merged[RSASR_LIMIT_MSB:0];
        end else if (wr_go && st.addr == RSASR_ADDR_LOWER) begin
            next_st.lower = merged[RSASR_LIMIT_MSB:0];
        end

        // conversion tracking
        next_st.upd = conv_done;
        if (conv_done) begin
            next_st.sup_under = supply_under;
            next_st.sup_over = supply_over;
        end
        if (conv_start) begin
            next_st.applied_range = st.range_code;
        end

        // latched flags: clear on read, a new trip wins
        if (rd_alarm) begin
            next_st.tripped = '0;
        end
        if (st.upd) begin
            next_st.tripped = next_st.tripped | act_vec;
        end

        // bus sequencing
        case (st.bus)
            RSASR_ST_READ: begin
                next_st.hrdata = rd_sel;
                next_st.hreadyout = 1'b1;
                next_st.bus = RSASR_ST_IDLE;
            end
            default: begin
                next_st.bus = RSASR_ST_IDLE;
                next_st.hreadyout = 1'b1;
                if (hsel && hready && htrans[1]) begin
                    next_st.addr = {haddr[7:2], 2'b00};
                    next_st.be = lane_mask(hsize, haddr[1:0]);
                    if (hwrite) begin
                        next_st.bus = RSASR_ST_WRITE;
                    end else begin
                        next_st.bus = RSASR_ST_READ;
                        next_st.hreadyout = 1'b0;
                    end
                end
            end
        endcase
        next_st.hresp = RSASR_HRESP_OKAY;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= RSASR_MAIN_RST;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout            = st.hreadyout;
    assign hrdata               = st.hrdata;
    assign hresp                = st.hresp;
    assign applied_range        = st.applied_range;
    assign onchip_reference_off = st.ref_off;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_range_low_byte:  assert property (
        wr_go && st.addr == RSASR_ADDR_RANGE && st.be[0]
        |=> st.range_code == $past(hwdata[RSASR_RANGE_MSB:RSASR_RANGE_LSB]))
        else $error("range byte write not stored");
    a_ref_off_write:   assert property (
        wr_go && st.addr == RSASR_ADDR_RANGE && st.be[0]
        |=> onchip_reference_off == $past(hwdata[RSASR_BIT_REF_OFF]))
        else $error("reference control not stored");
    a_range_reserved:  assert property (
        st.bus == RSASR_ST_READ && st.addr == RSASR_ADDR_RANGE
        |=> hrdata[31:7] == 25'h0 && hrdata[5:4] == 2'h0)
        else $error("range reserved bits read nonzero");
    a_alarm_reserved:  assert property (
        rd_alarm |=> hrdata[31:16] == 16'h0 && hrdata[13:12] == 2'h0
                     && hrdata[9:8] == 2'h0 && hrdata[3:1] == 3'h0)
        else $error("alarm reserved bits read nonzero");
    a_alarm_summary:   assert property (
        rd_alarm |=> hrdata[RSASR_BIT_ANY_TRIP] == |hrdata[7:4])
        else $error("summary flag not the or of latched flags");
    a_alarm_map:       assert property (
        rd_alarm |=> hrdata[RSASR_BIT_IN_UNDER] == $past(in_act[1])
                     && hrdata[RSASR_BIT_SUP_UNDER] == $past(st.sup_under)
                     && hrdata[7:4] == $past(st.tripped))
        else $error("alarm word fields misplaced");
    a_trip_sticky:     assert property (
        st.tripped[3] && !rd_alarm |=> st.tripped[3])
        else $error("latched flag dropped without a read");
    a_supply_active:   assert property (
        conv_done |=> ##1 st.tripped[2] == 1'b0 || $past(st.sup_over)
                     || $past(st.tripped[2]))
        else $error("supply over flag latched without alarm");
    a_range_applied:   assert property (
        conv_start |=> applied_range == $past(st.range_code))
        else $error("range not applied at conversion start");
    a_range_held:      assert property (
        !conv_start |=> $stable(applied_range))
        else $error("range changed during a conversion");
    a_read_wait:       assert property (
        hsel && hready && htrans[1] && !hwrite && st.bus != RSASR_ST_READ
        |=> !hreadyout ##1 hreadyout)
        else $error("read answer not after one wait state");
    a_write_no_wait:   assert property (
        hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write inserted a wait state");
    a_hresp_okay:      assert property (hresp == RSASR_HRESP_OKAY)
        else $error("slave answered with an error");
    a_rdata_hold:      assert property (
        st.bus != RSASR_ST_READ |=> $stable(hrdata))
        else $error("read data changed outside a read");
    a_alarm_no_write:  assert property (
        wr_go && st.addr == RSASR_ADDR_ALARM && !st.upd
        |=> st.tripped == $past(st.tripped))
        else $error("alarm register took a write");
    a_trip_clear_read: assert property (
        rd_alarm && !st.upd |=> st.tripped == '0)
        else $error("latched flags not cleared by read");
    a_trip_on_update:  assert property (
        st.upd |=> (st.tripped & $past(act_vec)) == $past(act_vec))
        else $error("active alarm not latched");
    a_supply_sample:   assert property (
        conv_done |=> st.sup_under == $past(supply_under)
                      && st.sup_over == $past(supply_over))
        else $error("supply flags not sampled at conversion");
    a_supply_hold:     assert property (
        !conv_done |=> $stable(st.sup_under) && $stable(st.sup_over))
        else $error("supply flags moved without a conversion");
    a_unmapped_zero:   assert property (
        st.bus == RSASR_ST_READ && st.addr != RSASR_ADDR_RANGE
        && st.addr != RSASR_ADDR_ALARM && st.addr != RSASR_ADDR_UPPER
        && st.addr != RSASR_ADDR_LOWER && st.addr != RSASR_ADDR_IRQ_STAT
        && st.addr != RSASR_ADDR_IRQ_MASK |=> hrdata == 32'h0000_0000)
        else $error("unmapped address read nonzero");
    a_upper_reserved:  assert property (
        st.bus == RSASR_ST_READ && st.addr == RSASR_ADDR_UPPER
        |=> hrdata[23:16] == 8'h00)
        else $error("threshold reserved bits read nonzero");
    a_lower_reserved:  assert property (
        st.bus == RSASR_ST_READ && st.addr == RSASR_ADDR_LOWER
        |=> hrdata[31:16] == 16'h0000)
        else $error("lower limit reserved bits read nonzero");
    a_hyst_write:      assert property (
        wr_go && st.addr == RSASR_ADDR_UPPER && st.be[3]
        |=> st.hyst_byte == $past(hwdata[31:24]))
        else $error("hysteresis byte not stored");
    a_upper_write:     assert property (
        wr_go && st.addr == RSASR_ADDR_UPPER && st.be[1] && st.be[0]
        |=> st.upper == $past(hwdata[15:0]))
        else $error("upper limit not stored");
    a_lower_write:     assert property (
        wr_go && st.addr == RSASR_ADDR_LOWER && st.be[1] && st.be[0]
        |=> st.lower == $past(hwdata[15:0]))
        else $error("lower limit not stored");
    a_ref_off_hold:    assert property (
        !(wr_go && st.addr == RSASR_ADDR_RANGE)
        |=> $stable(onchip_reference_off))
        else $error("reference control moved without a write");

    c_alarm_read_set:  cover property (rd_alarm && |st.tripped);
    c_unipolar_used:   cover property (
        conv_start && st.range_code == RSASR_UNI_1_25);
    c_irq_rise:        cover property (!irq ##1 irq);
    c_write_then_read: cover property (wr_go ##2 st.bus == RSASR_ST_READ);
    c_hyst_band:       cover property (conv_done && |st.hyst_byte[7:4]);
endmodule

// ---- tb/rsasr_regs_tb.sv ----
// self-checking bench of the range select and alarm status bank
`timescale 1ns/1ns
module rsasr_regs_tb;
    import rsasr_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic [1:0]  hresp;
    logic        conv_start = 1'b0;
    logic        conv_done = 1'b0;
    logic [13:0] conv_result = 14'h0;
    logic        supply_under = 1'b0;
    logic        supply_over = 1'b0;
    logic [3:0]  applied_range;
    logic        onchip_reference_off;
    logic        irq;
    logic [31:0] rd;
    logic [3:0]  codes [9] = '{4'hB, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8,
                               4'h9, 4'hA};
    int          n_errors = 0;
    int          comparisons = 0;
    `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
        n_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
    always #10 hclk = ~hclk;
    rsasr_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .conv_start(conv_start),
        .conv_done(conv_done), .conv_result(conv_result),
        .supply_under(supply_under), .supply_over(supply_over),
        .applied_range(applied_range),
        .onchip_reference_off(onchip_reference_off), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            close_out();
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic rchk(input string n, input logic [31:0] a, e);
        xfer(1'b0, a, 32'h0);
        `CHK(n, e, rd)
        `CHK("hresp", RSASR_HRESP_OKAY, hresp)
    endtask
    task automatic pulse_done();
        conv_done <= 1'b1;
        @(posedge hclk);
        conv_done <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk("range_rst", 32'h14, 32'h0);
        rchk("alarm_rst", 32'h20, 32'h0);
        rchk("upper_rst", 32'h24, 32'h0000FFFF);
        rchk("lower_rst", 32'h28, 32'h0);
        `CHK("ref_off_rst", 1'b0, onchip_reference_off)
    endtask
    task automatic t_range();
        xfer(1'b1, 32'h14, 32'hFFFFFFCB);
        rchk("range_rsv", 32'h14, 32'h0000004B);
        `CHK("ref_off", 1'b1, onchip_reference_off)
        foreach (codes[i]) begin
            xfer(1'b1, 32'h14, {28'h0, codes[i]});
            `CHK("range_hold", (i == 0) ? 4'h0 : codes[i-1], applied_range)
            conv_start <= 1'b1;
            @(posedge hclk);
            conv_start <= 1'b0;
            @(posedge hclk);
            `CHK("range_apply", codes[i], applied_range)
        end
    endtask
    task automatic t_alarm();
        xfer(1'b1, 32'h24, 32'h00000100);
        xfer(1'b1, 32'h34, 32'hF);
        supply_under <= 1'b1;
        conv_result <= 14'h50;
        pulse_done();
        `CHK("irq_on", 1'b1, irq)
        rchk("irq_stat", 32'h30, 32'h9);
        rchk("alarm_trip", 32'h20, 32'h00008491);
        rchk("alarm_clr", 32'h20, 32'h00008400);
        xfer(1'b1, 32'h30, 32'hF);
        @(posedge hclk);
        `CHK("irq_clr", 1'b0, irq)
        xfer(1'b1, 32'h20, 32'hFFFFFFFF);
        xfer(1'b1, 32'h28, 32'h00000200);
        xfer(1'b1, 32'h34, 32'h0);
        supply_under <= 1'b0;
        supply_over <= 1'b1;
        conv_result <= 14'h10;
        pulse_done();
        `CHK("irq_masked", 1'b0, irq)
        rchk("alarm_two", 32'h20, 32'h00004861);
        rchk("irq_stat2", 32'h30, 32'h6);
        xfer(1'b1, 32'h34, 32'hF);
        @(posedge hclk);
        `CHK("irq_unmask", 1'b1, irq)
        rchk("unmapped", 32'h40, 32'h0);
    endtask
    task automatic t_hyst();
        xfer(1'b1, 32'h24, 32'h30000100);
        xfer(1'b1, 32'h28, 32'h0);
        supply_over <= 1'b0;
        conv_result <= 14'h50;
        pulse_done();
        conv_result <= 14'h3E;
        pulse_done();
        rchk("hyst_band", 32'h20, 32'h00000411);
        conv_result <= 14'h3C;
        pulse_done();
        rchk("hyst_free", 32'h20, 32'h0);
        rchk("upper_hyst", 32'h24, 32'h30000100);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_range();
        t_alarm();
        t_hyst();
        close_out();
    end
    initial begin
        repeat (100000) @(posedge hclk);
        n_errors++;
        close_out();
    end
endmodule
